// ==== core/rx_datapath_consts.vh ====
/*
  Constants for the receive FIFO data path: register byte offsets,
  field positions, reset values and fixed widths.
  Assumes inclusion by bare name from the design file.
*/
`ifndef RX_DATAPATH_CONSTS_VH
`define RX_DATAPATH_CONSTS_VH

// register byte offsets, address bits 7:0 decoded
`define ADDR_RX_DATA     8'h00
`define ADDR_RX_STAT     8'h04
`define ADDR_RX_CFG      8'h08
`define ADDR_FIFO_INFO   8'h0c
`define ADDR_DP_CTRL     8'h10
`define ADDR_CTRL        8'h14

// receive configuration fields
`define CFG_OFFSET_HI    4
`define CFG_OFFSET_LO    0
`define CFG_PAD_EN       8
`define CFG_BURST_HI     10
`define CFG_BURST_LO     9
`define CFG_DUMP         15
`define CFG_OFFSET_RST   5'h00
`define CFG_BURST_RST    2'h0

// datapath control field
`define DPC_FFWD         31

// control and status fields
`define CTL_RX_EN        0
`define CTL_TX_ON        1
`define CTL_TX_STOP      2
`define CTL_SRST         3
`define CTL_RX_ERR       4

// status word and info layout
`define STAT_LEN_HI      29
`define STAT_LEN_LO      16
`define INFO_STAT_LO     16

// bus encodings and counters
`define HTRANS_ACT_BIT   1
`define HALF_W           16
`define WCNT_W           13

`endif

// ==== core/rx_fifo_host_datapath.v ====
/*
  Receive data FIFO, receive status FIFO and transmitter stop control,
  reached over an AHB-Lite slave with one wait state per transfer.
  Assumes the receive MAC layer and transmitter run on REF_CLK_IN.
*/
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "rx_datapath_consts.vh"
module rx_fifo_host_datapath #(
  parameter DATA_AW = 8,
  parameter STAT_AW = 4,
  // boundary queue deeper than status, so a status overrun can happen
  parameter BND_AW  = 5
) (
  // clock and reset
  input  wire        REF_CLK_IN,
  input  wire        RST_N_IN,
  // ahb-lite slave
  input  wire        HSEL_IN,
  input  wire [31:0] HADDR_IN,
  input  wire [1:0]  HTRANS_IN,
  input  wire        HWRITE_IN,
  input  wire [2:0]  HSIZE_IN,
  input  wire [31:0] HWDATA_IN,
  input  wire        HREADY_IN,
  output reg  [31:0] HRDATA_OUT,
  output reg         HREADYOUT_OUT,
  output reg         HRESP_OUT,
  // receive mac interface layer
  input  wire        MAC_DATA_VALID_IN,
  input  wire [31:0] MAC_DATA_IN,
  input  wire        MAC_STATUS_VALID_IN,
  input  wire [31:0] MAC_STATUS_IN,
  input  wire        MAC_RX_ACTIVE_IN,
  output wire        MAC_READY_OUT,
  output reg         RX_ENABLE_OUT,
  // transmitter control
  input  wire        TX_BUSY_IN,
  input  wire        TX_STATUS_VALID_IN,
  output reg         TX_ENABLE_OUT,
  // events
  output reg         TX_STOPPED_IRQ_OUT,
  output reg         RX_STOPPED_IRQ_OUT,
  output reg         RECEIVER_ERROR_FLAG_OUT
);
  localparam [2:0] W_IDLE  = 3'h0;
  localparam [2:0] W_LEAD  = 3'h1;
  localparam [2:0] W_DATA  = 3'h2;
  localparam [2:0] W_FLUSH = 3'h3;
  localparam [2:0] W_PAD   = 3'h4;
  localparam [2:0] W_STAT  = 3'h5;
  localparam [DATA_AW:0] D_ROOM = {1'b0, {DATA_AW{1'b1}}} - 1'b1;
  localparam [STAT_AW:0] S_FULL = {1'b1, {STAT_AW{1'b0}}};
  localparam [BND_AW:0]  B_FULL = {1'b1, {BND_AW{1'b0}}};

  reg [31:0]      dmem [0:(1<<DATA_AW)-1];
  reg [31:0]      smem [0:(1<<STAT_AW)-1];
  reg [DATA_AW:0] bmem [0:(1<<BND_AW)-1];
  reg [DATA_AW:0] dwp_q, drp_q;
  reg [STAT_AW:0] swp_q, srp_q;
  reg [BND_AW:0]  bwp_q, brp_q;
  reg [2:0]       ws_q;
  reg [`WCNT_W-1:0] wcnt_q, need_q;
  reg [2:0]       lead_q;
  reg [4:0]       off_q;
  reg [31:0]      carry_q, stat_q;
  reg             pad_q, mac_ready_q, ovf_q;
  reg [1:0]       blog_q;
  reg [4:0]       cfg_off_q;
  reg             cfg_pad_q, dump_q, srst_q, half_q, rx_done_q;
  reg [1:0]       cfg_blog_q;
  reg             rx_fast_forward_q, tx_on_q, tx_stop_q;
  reg             dp_q, dp_wr_q;
  reg [7:0]       dp_addr_q;
  reg             d_push, pad_need;
  reg [31:0]      d_wdata, rd_val;
  reg [63:0]      shifted;
  reg [`WCNT_W-1:0] bmask;

  wire [DATA_AW:0] d_used = dwp_q - drp_q;
  wire [STAT_AW:0] s_used = swp_q - srp_q;
  wire [BND_AW:0]  b_used = bwp_q - brp_q;
  wire [DATA_AW:0] b_head = bmem[brp_q[BND_AW-1:0]];
  wire [31:0]      d_head = dmem[drp_q[DATA_AW-1:0]];
  wire             d_room = (d_used <= D_ROOM);
  wire             flush  = dump_q | srst_q;
  wire take_data = (ws_q == W_DATA) && mac_ready_q && MAC_DATA_VALID_IN;
  wire take_stat = (ws_q == W_DATA) && mac_ready_q &&
                   !MAC_DATA_VALID_IN && MAC_STATUS_VALID_IN;
  wire [14:0] tot = {1'b0, MAC_STATUS_IN[`STAT_LEN_HI:`STAT_LEN_LO]} +
                    {10'h000, off_q} + 15'h0003;
  wire b_push = (ws_q == W_STAT) && (b_used != B_FULL) && !flush;
  wire s_push = b_push && (s_used != S_FULL);
  wire rd      = dp_q && !dp_wr_q;
  wire wr      = dp_q && dp_wr_q;
  wire rd_data = rd && (dp_addr_q == `ADDR_RX_DATA);
  wire rd_stat = rd && (dp_addr_q == `ADDR_RX_STAT);

  assign MAC_READY_OUT = mac_ready_q;

  // write side datapath
  always @* begin
    shifted  = {32'h00000000, MAC_DATA_IN} << {off_q[1:0], 3'b000};
    bmask    = (13'h0001 << blog_q) - 13'h0001;
    pad_need = pad_q && ((wcnt_q & bmask) != 13'h0000);
    d_push   = 1'b0;
    d_wdata  = 32'h00000000;
    case (ws_q)
      W_LEAD: d_push = d_room;
      W_DATA: begin
        d_push  = take_data;
        d_wdata = shifted[31:0] | carry_q;
      end
      W_FLUSH: begin
        d_push  = (wcnt_q < need_q) && d_room;
        d_wdata = carry_q;
      end
      W_PAD: d_push = pad_need && d_room;
      default: d_push = 1'b0;
    endcase
    if (flush) begin
      d_push = 1'b0;
    end
  end

  // memories carry no reset
  always @(posedge REF_CLK_IN) begin
    if (d_push) begin
      dmem[dwp_q[DATA_AW-1:0]] <= d_wdata;
    end
    if (s_push) begin
      smem[swp_q[STAT_AW-1:0]] <= stat_q;
    end
    if (b_push) begin
      bmem[bwp_q[BND_AW-1:0]] <= dwp_q;
    end
  end

  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ws_q <= W_IDLE;
      dwp_q <= {(DATA_AW+1){1'b0}};
      swp_q <= {(STAT_AW+1){1'b0}};
      bwp_q <= {(BND_AW+1){1'b0}};
      wcnt_q <= {`WCNT_W{1'b0}};
      need_q <= {`WCNT_W{1'b0}};
      lead_q <= 3'h0;
      off_q <= `CFG_OFFSET_RST;
      carry_q <= 32'h00000000;
      stat_q <= 32'h00000000;
      pad_q <= 1'b0;
      blog_q <= `CFG_BURST_RST;
      mac_ready_q <= 1'b0;
      ovf_q <= 1'b0;
    end else if (flush) begin
      ws_q <= W_IDLE;
      dwp_q <= {(DATA_AW+1){1'b0}};
      swp_q <= {(STAT_AW+1){1'b0}};
      bwp_q <= {(BND_AW+1){1'b0}};
      carry_q <= 32'h00000000;
      mac_ready_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      if (d_push) begin
        dwp_q <= dwp_q + 1'b1;
        wcnt_q <= wcnt_q + 1'b1;
      end
      if (s_push) begin
        swp_q <= swp_q + 1'b1;
      end
      if (b_push) begin
        bwp_q <= bwp_q + 1'b1;
      end
      ovf_q <= b_push && !s_push;
      mac_ready_q <= (ws_q == W_DATA) && !take_stat && d_room;
      case (ws_q)
        W_IDLE: if (MAC_DATA_VALID_IN || MAC_STATUS_VALID_IN) begin
          off_q <= cfg_off_q;
          lead_q <= cfg_off_q[4:2];
          pad_q <= cfg_pad_q;
          blog_q <= cfg_blog_q;
          carry_q <= 32'h00000000;
          wcnt_q <= {`WCNT_W{1'b0}};
          ws_q <= (cfg_off_q[4:2] != 3'h0) ? W_LEAD : W_DATA;
        end
        W_LEAD: if (d_push) begin
          lead_q <= lead_q - 3'h1;
          if (lead_q == 3'h1) begin
            ws_q <= W_DATA;
          end
        end
        W_DATA: if (take_data) begin
          carry_q <= shifted[63:32];
        end else if (take_stat) begin
          stat_q <= MAC_STATUS_IN;
          need_q <= tot[14:2];
          ws_q <= W_FLUSH;
        end
        W_FLUSH: if (d_push) begin
          carry_q <= 32'h00000000;
        end else if (wcnt_q >= need_q) begin
          ws_q <= W_PAD;
        end
        W_PAD: if (!pad_need) begin
          ws_q <= W_STAT;
        end
        W_STAT: if (b_used != B_FULL) begin
          ws_q <= W_IDLE;
        end
        default: ws_q <= W_IDLE;
      endcase
    end
  end

  // register read mux
  always @* begin
    rd_val = 32'h00000000;
    case (dp_addr_q)
      `ADDR_RX_DATA: if (d_used != {(DATA_AW+1){1'b0}}) begin
        rd_val[`HALF_W-1:0] = half_q ? d_head[31:`HALF_W] :
                                       d_head[`HALF_W-1:0];
      end
      `ADDR_RX_STAT: if (s_used != {(STAT_AW+1){1'b0}}) begin
        rd_val = smem[srp_q[STAT_AW-1:0]];
      end
      `ADDR_RX_CFG: begin
        rd_val[`CFG_OFFSET_HI:`CFG_OFFSET_LO] = cfg_off_q;
        rd_val[`CFG_PAD_EN] = cfg_pad_q;
        rd_val[`CFG_BURST_HI:`CFG_BURST_LO] = cfg_blog_q;
        rd_val[`CFG_DUMP] = dump_q;
      end
      `ADDR_FIFO_INFO: begin
        rd_val[DATA_AW:0] = d_used;
        rd_val[`INFO_STAT_LO+STAT_AW:`INFO_STAT_LO] = s_used;
      end
      `ADDR_DP_CTRL: rd_val[`DPC_FFWD] = rx_fast_forward_q;
      `ADDR_CTRL: begin
        rd_val[`CTL_RX_EN] = RX_ENABLE_OUT;
        rd_val[`CTL_TX_ON] = tx_on_q;
        rd_val[`CTL_TX_STOP] = tx_stop_q;
        rd_val[`CTL_RX_ERR] = RECEIVER_ERROR_FLAG_OUT;
      end
      default: rd_val = 32'h00000000;
    endcase
  end

  // bus slave, read side and control
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      HRDATA_OUT <= 32'h00000000;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
      dp_q <= 1'b0;
      dp_wr_q <= 1'b0;
      dp_addr_q <= 8'h00;
      drp_q <= {(DATA_AW+1){1'b0}};
      srp_q <= {(STAT_AW+1){1'b0}};
      brp_q <= {(BND_AW+1){1'b0}};
      half_q <= 1'b0;
      cfg_off_q <= `CFG_OFFSET_RST;
      cfg_pad_q <= 1'b0;
      cfg_blog_q <= `CFG_BURST_RST;
      dump_q <= 1'b0;
      srst_q <= 1'b0;
      rx_fast_forward_q <= 1'b0;
      RX_ENABLE_OUT <= 1'b0;
      tx_on_q <= 1'b0;
      tx_stop_q <= 1'b0;
      TX_ENABLE_OUT <= 1'b0;
      TX_STOPPED_IRQ_OUT <= 1'b0;
      RX_STOPPED_IRQ_OUT <= 1'b0;
      RECEIVER_ERROR_FLAG_OUT <= 1'b0;
      rx_done_q <= 1'b1;
    end else begin
      TX_STOPPED_IRQ_OUT <= 1'b0;
      RX_STOPPED_IRQ_OUT <= 1'b0;
      // dump and soft reset last one cycle
      dump_q <= 1'b0;
      srst_q <= 1'b0;
      // one wait state lets read data come from a flop
      if (dp_q) begin
        dp_q <= 1'b0;
        HREADYOUT_OUT <= 1'b1;
        HRDATA_OUT <= rd ? rd_val : 32'h00000000;
      end else if (HSEL_IN && HTRANS_IN[`HTRANS_ACT_BIT] && HREADY_IN) begin
        dp_q <= 1'b1;
        dp_wr_q <= HWRITE_IN;
        dp_addr_q <= HADDR_IN[7:0];
        HREADYOUT_OUT <= 1'b0;
      end
      if (rd_data && d_used != {(DATA_AW+1){1'b0}}) begin
        half_q <= !half_q;
        if (half_q) begin
          drp_q <= drp_q + 1'b1;
        end
      end
      if (rd_stat && s_used != {(STAT_AW+1){1'b0}}) begin
        srp_q <= srp_q + 1'b1;
      end
      if (b_used != {(BND_AW+1){1'b0}} && b_head == drp_q) begin
        brp_q <= brp_q + 1'b1;
      end else if (rx_fast_forward_q && b_used != {(BND_AW+1){1'b0}}) begin
        drp_q <= b_head;
        brp_q <= brp_q + 1'b1;
        half_q <= 1'b0;
        rx_fast_forward_q <= 1'b0;
      end
      if (srst_q) begin
        RECEIVER_ERROR_FLAG_OUT <= 1'b0;
      end
      // underrun sets error, set beats clear
      if ((rd_data && d_used == {(DATA_AW+1){1'b0}}) || ovf_q ||
          (rd_stat && s_used == {(STAT_AW+1){1'b0}})) begin
        RECEIVER_ERROR_FLAG_OUT <= 1'b1;
      end
      if (tx_stop_q && (TX_STATUS_VALID_IN || !TX_BUSY_IN)) begin
        tx_on_q <= 1'b0;
        tx_stop_q <= 1'b0;
        TX_STOPPED_IRQ_OUT <= 1'b1;
      end
      TX_ENABLE_OUT <= tx_on_q && !tx_stop_q;
      if (RX_ENABLE_OUT) begin
        rx_done_q <= 1'b0;
      end else if (!MAC_RX_ACTIVE_IN && !rx_done_q) begin
        rx_done_q <= 1'b1;
        RX_STOPPED_IRQ_OUT <= 1'b1;
      end
      if (wr && dp_addr_q == `ADDR_RX_CFG) begin
        cfg_off_q <= HWDATA_IN[`CFG_OFFSET_HI:`CFG_OFFSET_LO];
        cfg_pad_q <= HWDATA_IN[`CFG_PAD_EN];
        cfg_blog_q <= HWDATA_IN[`CFG_BURST_HI:`CFG_BURST_LO];
        dump_q <= HWDATA_IN[`CFG_DUMP];
      end
      if (wr && dp_addr_q == `ADDR_DP_CTRL && HWDATA_IN[`DPC_FFWD]) begin
        rx_fast_forward_q <= 1'b1;
      end
      if (wr && dp_addr_q == `ADDR_CTRL) begin
        RX_ENABLE_OUT <= HWDATA_IN[`CTL_RX_EN];
        tx_on_q <= HWDATA_IN[`CTL_TX_ON];
        tx_stop_q <= HWDATA_IN[`CTL_TX_STOP];
        srst_q <= HWDATA_IN[`CTL_SRST];
      end
      if (flush) begin
        drp_q <= {(DATA_AW+1){1'b0}};
        srp_q <= {(STAT_AW+1){1'b0}};
        brp_q <= {(BND_AW+1){1'b0}};
        half_q <= 1'b0;
        rx_fast_forward_q <= 1'b0;
      end
    end
  end
endmodule // rx_fifo_host_datapath

// ==== verif/rx_fifo_host_datapath_properties.sv ====
/* port checker for the receive fifo datapath.
   assumes HREADY_IN is tied to HREADYOUT_OUT. */
`timescale 1ns/1ps
module rx_dp_checker (
  // clock and reset
  input wire        REF_CLK_IN,
  input wire        RST_N_IN,
  // bus
  input wire        HSEL_IN,
  input wire [1:0]  HTRANS_IN,
  input wire        HREADY_IN,
  input wire [31:0] HRDATA_OUT,
  input wire        HREADYOUT_OUT,
  input wire        HRESP_OUT,
  // mac and transmitter
  input wire        MAC_DATA_VALID_IN,
  input wire        MAC_STATUS_VALID_IN,
  input wire        MAC_READY_OUT,
  input wire        RX_ENABLE_OUT,
  input wire        TX_BUSY_IN,
  input wire        TX_STATUS_VALID_IN,
  input wire        TX_ENABLE_OUT,
  input wire        TX_STOPPED_IRQ_OUT,
  input wire        RX_STOPPED_IRQ_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  a_one_wait: assert property (
    HSEL_IN && HTRANS_IN[1] && HREADY_IN && HREADYOUT_OUT
    |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT) else $error("bad wait state");
  a_resp_okay: assert property (
    HRESP_OUT == 1'b0) else $error("response not okay");
  a_rdata_hold: assert property (
    HREADYOUT_OUT && $past(HREADYOUT_OUT) |-> $stable(HRDATA_OUT))
    else $error("read data moved while idle");
  a_txirq_cause: assert property (
    TX_STOPPED_IRQ_OUT |-> !$past(TX_BUSY_IN) || $past(TX_STATUS_VALID_IN))
    else $error("tx stopped mid frame");
  a_txirq_off: assert property (
    TX_STOPPED_IRQ_OUT |-> !TX_ENABLE_OUT ##1 !TX_ENABLE_OUT)
    else $error("tx still enabled after stop");
  a_txirq_pulse: assert property (
    TX_STOPPED_IRQ_OUT |=> !TX_STOPPED_IRQ_OUT) else $error("tx pulse long");
  a_rxirq_pulse: assert property (
    RX_STOPPED_IRQ_OUT |-> !RX_ENABLE_OUT ##1 !RX_STOPPED_IRQ_OUT)
    else $error("rx stop pulse wrong");
  a_stat_ends: assert property (
    MAC_READY_OUT && MAC_STATUS_VALID_IN && !MAC_DATA_VALID_IN
    |=> !MAC_READY_OUT) else $error("ready kept after status");
endmodule // rx_dp_checker

bind rx_fifo_host_datapath rx_dp_checker chk (
  .REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN), .HSEL_IN(HSEL_IN),
  .HTRANS_IN(HTRANS_IN), .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT),
  .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
  .MAC_DATA_VALID_IN(MAC_DATA_VALID_IN),
  .MAC_STATUS_VALID_IN(MAC_STATUS_VALID_IN),
  .MAC_READY_OUT(MAC_READY_OUT), .RX_ENABLE_OUT(RX_ENABLE_OUT),
  .TX_BUSY_IN(TX_BUSY_IN), .TX_STATUS_VALID_IN(TX_STATUS_VALID_IN),
  .TX_ENABLE_OUT(TX_ENABLE_OUT), .TX_STOPPED_IRQ_OUT(TX_STOPPED_IRQ_OUT),
  .RX_STOPPED_IRQ_OUT(RX_STOPPED_IRQ_OUT));

// ==== verif/mac_source.sv ====
/* receive mac layer model: words then one status per frame.
   assumes send is called just after a rising clock edge. */
`timescale 1ns/1ps
module mac_source (
  // clock and handshake
  input  wire         clk_in,
  input  wire         ready_in,
  // frame words
  output logic        valid_out,
  output logic [31:0] data_out,
  output logic        stat_valid_out,
  output logic [31:0] stat_out,
  output logic        active_out
);
  initial begin
    valid_out = 1'b0;
    data_out = 32'h0;
    stat_valid_out = 1'b0;
    stat_out = 32'h0;
    active_out = 1'b0;
  end
  task send(input int nw, input [31:0] base);
    active_out <= 1'b1;
    for (int i = 0; i < nw; i++) begin
      valid_out <= 1'b1;
      data_out <= base + i;
      @(posedge clk_in);
      while (!ready_in) @(posedge clk_in);
    end
    valid_out <= 1'b0;
    // released lines never keep the old value
    data_out <= ~data_out;
    stat_valid_out <= 1'b1;
    stat_out <= (nw * 4) << 16;
    @(posedge clk_in);
    while (!ready_in) @(posedge clk_in);
    stat_valid_out <= 1'b0;
    stat_out <= ~stat_out;
    active_out <= 1'b0;
    // one idle edge so the next frame never reassigns active_out
    @(posedge clk_in);
  endtask
endmodule // mac_source

// ==== verif/test_rx_fifo_host_datapath.sv ====
/* self-checking bench for the receive fifo datapath.
   assumes a status fifo depth of 16 and one-wait-state bus. */
`timescale 1ns/1ps
module test_rx_fifo_host_datapath;
  logic        clk, rst_n, hsel, hwrite, hrdy, hresp, tx_busy, tx_st;
  logic        dv, sv, act, mrdy, rx_en, tx_en, tx_irq, rx_irq, err;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, w, md, ms;
  int          fails, tests_run, n;

  rx_fifo_host_datapath uut (
    .REF_CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwdata), .HREADY_IN(hrdy), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp), .MAC_DATA_VALID_IN(dv),
    .MAC_DATA_IN(md), .MAC_STATUS_VALID_IN(sv), .MAC_STATUS_IN(ms),
    .MAC_RX_ACTIVE_IN(act), .MAC_READY_OUT(mrdy), .RX_ENABLE_OUT(rx_en),
    .TX_BUSY_IN(tx_busy), .TX_STATUS_VALID_IN(tx_st),
    .TX_ENABLE_OUT(tx_en), .TX_STOPPED_IRQ_OUT(tx_irq),
    .RX_STOPPED_IRQ_OUT(rx_irq), .RECEIVER_ERROR_FLAG_OUT(err));
  mac_source mac (.clk_in(clk), .ready_in(mrdy), .valid_out(dv),
    .data_out(md), .stat_valid_out(sv), .stat_out(ms), .active_out(act));

  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one single transfer; called just after a rising edge
  task bus(input w1, input [7:0] a, input [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w1;
    @(posedge clk);
    while (!hrdy) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (!hrdy) @(posedge clk);
    rd = hrdata;
  endtask
  task poll(input [7:0] a, input [31:0] m, input [31:0] v);
    n = 0;
    bus(1'b0, a, 32'h0);
    while ((rd & m) !== v && n < 200) begin
      bus(1'b0, a, 32'h0);
      n++;
    end
  endtask
  task flush;
    bus(1'b1, 8'h14, 32'h0);
    n = 0;
    while (!rx_irq && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk("rx_stop_pulse", rx_irq, 1);
    bus(1'b1, 8'h08, 32'h8000);
    poll(8'h08, 32'h8000, 32'h0);
    chk("dump_bit", rd[15], 0);
    bus(1'b0, 8'h0c, 32'h0);
    chk("dump_info", rd, 0);
    bus(1'b1, 8'h14, 32'h1);
  endtask
  task s_basic;
    mac.send(4, 32'h11223340);
    mac.send(1, 32'ha5a50000);
    poll(8'h0c, 32'hff0000, 32'h20000);
    chk("info_words", rd[8:0], 5);
    bus(1'b0, 8'h04, 32'h0);
    chk("stat0", rd, 32'h00100000);
    bus(1'b0, 8'h04, 32'h0);
    chk("stat1", rd, 32'h00040000);
    for (int i = 0; i < 5; i++) begin
      w = (i < 4) ? 32'h11223340 + i : 32'ha5a50000;
      bus(1'b0, 8'h00, 32'h0);
      chk("data_lo", rd, {16'h0, w[15:0]});
      bus(1'b0, 8'h00, 32'h0);
      chk("data_hi", rd, {16'h0, w[31:16]});
    end
    bus(1'b0, 8'h0c, 32'h0);
    chk("info_drained", rd, 0);
  endtask
  task s_under;
    bus(1'b0, 8'h00, 32'h0);
    chk("under_data", rd, 0);
    chk("err_flag", err, 1);
    bus(1'b1, 8'h14, 32'h9);
    bus(1'b0, 8'h04, 32'h0);
    chk("under_stat", rd, 0);
    bus(1'b1, 8'h14, 32'h9);
    bus(1'b0, 8'h14, 32'h0);
    chk("err_cleared", rd[4], 0);
  endtask
  task s_offset;
    bus(1'b1, 8'h08, 32'h6);
    mac.send(2, 32'h44332211);
    poll(8'h0c, 32'hff0000, 32'h10000);
    chk("off_words", rd[8:0], 4);
    bus(1'b0, 8'h04, 32'h0);
    repeat (4) bus(1'b0, 8'h00, 32'h0);
    chk("off_shift", rd, 32'h2211);
    flush;
  endtask
  task s_pad;
    bus(1'b1, 8'h08, 32'h300);
    mac.send(5, 32'h100);
    mac.send(4, 32'h12340200);
    poll(8'h0c, 32'hff0000, 32'h20000);
    chk("pad_words", rd[8:0], 10);
    bus(1'b1, 8'h10, 32'h80000000);
    poll(8'h10, 32'h80000000, 32'h0);
    chk("ffwd_clear", rd[31], 0);
    bus(1'b0, 8'h0c, 32'h0);
    chk("ffwd_words", rd[8:0], 4);
    chk("ffwd_stat", rd[23:16], 2);
    bus(1'b0, 8'h04, 32'h0);
    chk("pad_len", rd, 32'h00140000);
    bus(1'b0, 8'h00, 32'h0);
    chk("ffwd_head", rd, 32'h0200);
    flush;
  endtask
  task s_over;
    bus(1'b1, 8'h08, 32'h0);
    for (int i = 0; i < 17; i++) mac.send(1, i);
    poll(8'h14, 32'h10, 32'h10);
    chk("ovr_err", err, 1);
    bus(1'b0, 8'h0c, 32'h0);
    chk("ovr_words", rd[8:0], 17);
    chk("ovr_stat", rd[23:16], 16);
    bus(1'b1, 8'h14, 32'h9);
  endtask
  task s_tx;
    bus(1'b1, 8'h14, 32'h3);
    @(posedge clk);
    chk("tx_on", tx_en, 1);
    tx_busy <= 1'b1;
    bus(1'b1, 8'h14, 32'h7);
    repeat (4) @(posedge clk);
    chk("tx_finishing", {tx_irq, tx_en}, 0);
    tx_st <= 1'b1;
    @(posedge clk);
    tx_st <= 1'b0;
    tx_busy <= 1'b0;
    @(posedge clk);
    chk("tx_irq", tx_irq, 1);
    bus(1'b0, 8'h14, 32'h0);
    chk("tx_bits", rd[2:1], 0);
    bus(1'b1, 8'h14, 32'h3);
    @(posedge clk);
    chk("tx_resume", tx_en, 1);
  endtask
  task close_out;
    if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // watchdog well beyond the expected few hundred cycles
  initial begin
    #300000;
    fails++;
    close_out;
  end
  initial begin
    fails = 0;
    tests_run = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    tx_busy = 1'b0;
    tx_st = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b1, 8'h14, 32'h1);
    s_basic;
    s_under;
    s_offset;
    s_pad;
    s_over;
    s_tx;
    close_out;
  end
endmodule // test_rx_fifo_host_datapath
